/* File: switch_status_pkg.sv */
package switch_status_pkg;

    // Register offsets (word index on the status read port)
    localparam logic [5:0] OFS_ADC_STATUS_GROUP3 = 6'h07;
    localparam logic [5:0] OFS_MATRIX_ROWS_10_13 = 6'h08;
    localparam logic [5:0] OFS_MATRIX_ROWS_14_15_COMMON = 6'h09;

    // Register geometry and reset value
    localparam int REG_W = 24;
    localparam logic [23:0] REG_RESET = 24'h000000;

    // Analog-level field positions in the group-3 register
    localparam int ADC18_LSB = 0;
    localparam int ADC19_LSB = 2;
    localparam int ADC_FIELD_W = 2;
    localparam int ADC_USED_W = 4;

    // Matrix geometry: rows 10..15, columns 4..9
    localparam int MAT_COLS = 6;
    localparam int MAT_ROWS = 6;
    localparam int MAT0_ROWS = 4;
    localparam int MAT1_ROW_LSB = 0;
    localparam int COM_LSB = 12;
    localparam int COM_INPUTS = 12;

    // Four-level analog codes
    localparam logic [1:0] LVL_BELOW_A = 2'h0;
    localparam logic [1:0] LVL_A_TO_B = 2'h1;
    localparam logic [1:0] LVL_B_TO_C = 2'h2;
    localparam logic [1:0] LVL_ABOVE_C = 2'h3;

    localparam int ADC_BITS = 10;

    typedef struct packed {
        logic valid;
        logic [9:0] value19;
        logic [9:0] value18;
    } adc_sample_t;

    typedef struct packed {
        logic [9:0] th3a;
        logic [9:0] th3b;
        logic [9:0] th3c;
    } adc_thresholds_t;

    typedef struct packed {
        logic valid;
        logic [2:0] col;
        logic [5:0] rows;
    } matrix_sample_t;

    typedef struct packed {
        logic valid;
        logic [11:0] above;
    } common_sample_t;

    typedef struct packed {
        logic rd;
        logic [5:0] addr;
    } rd_req_t;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } rd_rsp_t;

endpackage

/* File: status_capture.sv */
`timescale 1ns/1ps
`default_nettype none

// Bank of read-only status bits, each loaded only where its mask is set
module status_capture
    import switch_status_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] load_mask,
    input wire logic [W-1:0] load_data,
    output logic [W-1:0] bits
);

    typedef struct packed {
        logic [W-1:0] bits;
    } cap_state_t;

    cap_state_t state_r;
    cap_state_t state_nxt;

    // Unmasked bits hold their last sampled value
    always_comb begin
        state_nxt = state_r;
        state_nxt.bits = (state_r.bits & ~load_mask) | (load_data & load_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign bits = state_r.bits;

endmodule
`default_nettype wire

/* File: switch_matrix_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module switch_matrix_status_regs
    import switch_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire adc_sample_t adc_sample,
    input wire adc_thresholds_t adc_thresholds,
    input wire matrix_sample_t matrix_sample,
    input wire common_sample_t common_sample,
    input wire rd_req_t rd_req,
    output rd_rsp_t rd_rsp
);

    // Reset release synchroniser; assertion stays asynchronous.
    // Release passes two stages so it never meets the status flops mid-cycle.
    typedef struct packed {
        logic meta_b;
        logic sync_b;
    } rst_state_t;

    rst_state_t rst_r;
    rst_state_t rst_nxt;
    logic rst_sync_b_r;

    always_comb begin
        rst_nxt = rst_r;
        rst_nxt.meta_b = 1'b1;
        rst_nxt.sync_b = rst_r.meta_b;
    end

    // Only the second stage is read outside this block
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_r <= '0;
        end else begin
            rst_r <= rst_nxt;
        end
    end

    assign rst_sync_b_r = rst_r.sync_b;

    // Analog channels in field order: index 0 is input 18, index 1 is input 19.
    // Both share the one threshold set, but each channel has its own compare bank.
    localparam int ADC_CH = ADC_USED_W / ADC_FIELD_W;

    logic [ADC_CH-1:0][ADC_BITS-1:0] adc_value;
    logic [ADC_CH-1:0] ge_a;
    logic [ADC_CH-1:0] ge_b;
    logic [ADC_CH-1:0] ge_c;
    logic [ADC_CH-1:0][ADC_FIELD_W-1:0] adc_level;
    logic [ADC_USED_W-1:0] adc_mask;
    logic [ADC_USED_W-1:0] adc_data;
    logic [MAT_COLS-1:0] col_hot;
    logic [REG_W-1:0] mat0_mask;
    logic [REG_W-1:0] mat0_data;
    logic [REG_W-1:0] mat1_mask;
    logic [REG_W-1:0] mat1_data;
    logic [ADC_USED_W-1:0] adc_bits;
    logic [REG_W-1:0] mat0_bits;
    logic [REG_W-1:0] mat1_bits;

    // Threshold compares, each one "equal to or above"
    always_comb begin
        adc_value[0] = adc_sample.value18;
        adc_value[1] = adc_sample.value19;
        ge_a = '0;
        ge_b = '0;
        ge_c = '0;
        for (int ch = 0; ch < ADC_CH; ch++) begin
            ge_a[ch] = (adc_value[ch] >= adc_thresholds.th3a);
            ge_b[ch] = (adc_value[ch] >= adc_thresholds.th3b);
            ge_c[ch] = (adc_value[ch] >= adc_thresholds.th3c);
        end
    end

    // Highest threshold reached wins, so misordered thresholds still give a legal code
    always_comb begin
        adc_level = '0;
        for (int ch = 0; ch < ADC_CH; ch++) begin
            if (ge_c[ch]) begin
                adc_level[ch] = LVL_ABOVE_C;
            end else if (ge_b[ch]) begin
                adc_level[ch] = LVL_B_TO_C;
            end else if (ge_a[ch]) begin
                adc_level[ch] = LVL_A_TO_B;
            end else begin
                adc_level[ch] = LVL_BELOW_A;
            end
        end
    end

    always_comb begin
        adc_mask = {ADC_USED_W{adc_sample.valid}};
        adc_data = '0;
        adc_data[ADC19_LSB +: ADC_FIELD_W] = adc_level[1];
        adc_data[ADC18_LSB +: ADC_FIELD_W] = adc_level[0];
    end

    // Column one-hot; codes 6 and 7 select nothing rather than alias a column
    always_comb begin
        col_hot = '0;
        for (int c = 0; c < MAT_COLS; c++) begin
            col_hot[c] = matrix_sample.valid && (int'(matrix_sample.col) == c);
        end
    end

    // Scatter one polled column into both matrix registers.
    // Unselected columns leave their mask bits low, so those bits hold.
    always_comb begin
        mat0_mask = '0;
        mat0_data = '0;
        mat1_mask = '0;
        mat1_data = '0;
        for (int r = 0; r < MAT_ROWS; r++) begin
            for (int c = 0; c < MAT_COLS; c++) begin
                if (r < MAT0_ROWS) begin
                    mat0_mask[r*MAT_COLS + c] = col_hot[c];
                    mat0_data[r*MAT_COLS + c] = matrix_sample.rows[r];
                end else begin
                    // rows 14 and 15 low bits
                    mat1_mask[MAT1_ROW_LSB + (r-MAT0_ROWS)*MAT_COLS + c] = col_hot[c];
                    mat1_data[MAT1_ROW_LSB + (r-MAT0_ROWS)*MAT_COLS + c] = matrix_sample.rows[r];
                end
            end
        end
        if (common_sample.valid) begin
            mat1_mask[COM_LSB +: COM_INPUTS] = {COM_INPUTS{1'b1}};
            mat1_data[COM_LSB +: COM_INPUTS] = common_sample.above;
        end
    end

    status_capture #(.W(ADC_USED_W)) u_adc_cap (
        .clk(ref_clk),
        .rst_n(rst_sync_b_r),
        .load_mask(adc_mask),
        .load_data(adc_data),
        .bits(adc_bits)
    );

    status_capture #(.W(REG_W)) u_mat0_cap (
        .clk(ref_clk),
        .rst_n(rst_sync_b_r),
        .load_mask(mat0_mask),
        .load_data(mat0_data),
        .bits(mat0_bits)
    );

    status_capture #(.W(REG_W)) u_mat1_cap (
        .clk(ref_clk),
        .rst_n(rst_sync_b_r),
        .load_mask(mat1_mask),
        .load_data(mat1_data),
        .bits(mat1_bits)
    );

    // Read answer register; the only top-level state besides reset release
    typedef struct packed {
        rd_rsp_t rsp;
    } top_state_t;

    top_state_t state_r;
    top_state_t state_nxt;

    // Read decode; writes do not exist, unmapped offsets read zero.
    // Reads sample the held copies, so a read never sees a half update.
    always_comb begin
        state_nxt = state_r;
        state_nxt.rsp.valid = rd_req.rd;
        if (rd_req.rd) begin
            unique case (rd_req.addr)
                OFS_ADC_STATUS_GROUP3: begin
                    state_nxt.rsp.data = {{(REG_W-ADC_USED_W){1'b0}}, adc_bits};
                end
                OFS_MATRIX_ROWS_10_13: begin
                    state_nxt.rsp.data = mat0_bits;
                end
                OFS_MATRIX_ROWS_14_15_COMMON: begin
                    state_nxt.rsp.data = mat1_bits;
                end
                default: begin
                    state_nxt.rsp.data = REG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rd_rsp = state_r.rsp;

endmodule
`default_nettype wire

/* File: switch_matrix_status_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checks of the status read path
module switch_matrix_status_regs_asserts
    import switch_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire adc_sample_t adc_sample,
    input wire adc_thresholds_t adc_thresholds,
    input wire matrix_sample_t matrix_sample,
    input wire common_sample_t common_sample,
    input wire rd_req_t rd_req,
    input wire rd_rsp_t rd_rsp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_read_answer: assert property (rd_req.rd |=> rd_rsp.valid)
        else $error("read not answered");
    a_valid_pulse: assert property (!rd_req.rd |=> !rd_rsp.valid)
        else $error("valid without read");
    a_data_hold: assert property (!rd_req.rd |=> $stable(rd_rsp.data))
        else $error("data moved without read");
    a_unmapped_zero: assert property (
        rd_req.rd && rd_req.addr > OFS_MATRIX_ROWS_14_15_COMMON |=> rd_rsp.data == REG_RESET)
        else $error("unmapped read not zero");
    a_adc_upper: assert property (
        rd_req.rd && rd_req.addr == OFS_ADC_STATUS_GROUP3 |=> rd_rsp.data[23:4] == 20'h00000)
        else $error("unused level bits set");
    a_level_top: assert property (
        adc_sample.valid && adc_sample.value19 >= adc_thresholds.th3c
        ##1 rd_req.rd && rd_req.addr == OFS_ADC_STATUS_GROUP3 |=> rd_rsp.data[3:2] == 2'h3)
        else $error("top level code wrong");
    a_matrix_bit: assert property (
        matrix_sample.valid && matrix_sample.col < 3'h6
        ##1 rd_req.rd && rd_req.addr == OFS_MATRIX_ROWS_10_13
        |=> rd_rsp.data[$past(matrix_sample.col, 2)] == $past(matrix_sample.rows[0], 2))
        else $error("matrix bit wrong");
    a_common_bits: assert property (
        common_sample.valid ##1 rd_req.rd && rd_req.addr == OFS_MATRIX_ROWS_14_15_COMMON
        |=> rd_rsp.data[23:12] == $past(common_sample.above, 2))
        else $error("common bits wrong");
endmodule
bind switch_matrix_status_regs switch_matrix_status_regs_asserts switch_matrix_status_regs_asserts_inst (.*);
`default_nettype wire

/* File: host_reader.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: one word per request, called at a falling edge
module host_reader
    import switch_status_pkg::*;
(
    input wire logic ref_clk,
    input wire rd_rsp_t rd_rsp,
    output var rd_req_t rd_req
);
    initial rd_req = '0;
    // Answer stands only in the cycle after the taking edge, so take it there.
    // Released address is inverted so stale values never match.
    task automatic read_word(input logic [5:0] a, output logic [23:0] d, output logic ok);
        rd_req = '{1'b1, a};
        @(negedge ref_clk);
        d = rd_rsp.data;
        ok = rd_rsp.valid;
        rd_req = '{1'b0, ~a};
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: tb_switch_matrix_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_switch_matrix_status_regs;
    import switch_status_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    adc_sample_t adc_sample = '0;
    adc_thresholds_t adc_thresholds = '{10'h064, 10'h0C8, 10'h12C};
    matrix_sample_t matrix_sample = '0;
    common_sample_t common_sample = '0;
    rd_req_t rd_req;
    rd_rsp_t rd_rsp;
    int err_total = 0;
    int num_checks = 0;
    switch_matrix_status_regs switch_matrix_status_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .adc_sample(adc_sample), .adc_thresholds(adc_thresholds), .matrix_sample(matrix_sample),
        .common_sample(common_sample), .rd_req(rd_req), .rd_rsp(rd_rsp));
    host_reader host_reader_inst (.ref_clk(ref_clk), .rd_rsp(rd_rsp), .rd_req(rd_req));
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Read one word, then judge valid and data
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] d;
        logic ok;
        host_reader_inst.read_word(a, d, ok);
        check({23'h0, ok}, 24'h1);
        check(d, exp);
    endtask
    task automatic t_reset();
        for (int a = 7; a < 11; a++) rd_chk(6'(a), REG_RESET);
    endtask
    // Codes straddle thresholds A and C by one count; threshold B is only met exactly
    task automatic t_adc();
        logic [9:0] v [5] = '{10'h063, 10'h064, 10'h0C8, 10'h12B, 10'h12C};
        logic [1:0] c [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
        for (int i = 0; i < 5; i++) begin
            adc_sample = '{1'b1, v[i], v[4-i]};
            @(negedge ref_clk);
            adc_sample.valid = 1'b0;
            rd_chk(OFS_ADC_STATUS_GROUP3, {20'h0, c[i], c[4-i]});
        end
    endtask
    // Column 6 comes first and must be dropped
    task automatic t_matrix();
        logic [23:0] e8 = '0;
        logic [23:0] e9 = '0;
        int c;
        for (int i = 0; i < 7; i++) begin
            c = (i + 6) % 7;
            matrix_sample = '{1'b1, 3'(c), (c == 6) ? 6'h3F : (c % 2 == 1) ? 6'h2A : 6'h15};
            for (int r = 0; r < 6 && c < 6; r++) begin
                if (r < 4) e8[r*6+c] = matrix_sample.rows[r];
                else e9[(r-4)*6+c] = matrix_sample.rows[r];
            end
            @(negedge ref_clk);
        end
        matrix_sample.valid = 1'b0;
        rd_chk(OFS_MATRIX_ROWS_10_13, e8);
        rd_chk(OFS_MATRIX_ROWS_14_15_COMMON, e9);
    endtask
    // Second read with no sample must repeat the first
    task automatic t_common();
        common_sample = '{1'b1, 12'hA5C};
        @(negedge ref_clk);
        common_sample.valid = 1'b0;
        rd_chk(OFS_MATRIX_ROWS_14_15_COMMON, 24'hA5CA95);
        rd_chk(OFS_MATRIX_ROWS_14_15_COMMON, 24'hA5CA95);
    endtask
    // Reset in mid-run must clear bits loaded earlier
    task automatic t_mid_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_chk(OFS_MATRIX_ROWS_10_13, REG_RESET);
        rd_chk(OFS_MATRIX_ROWS_14_15_COMMON, REG_RESET);
    endtask
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_adc();
        t_matrix();
        t_common();
        t_mid_reset();
        final_report();
    end
    // Watchdog: run needs about 53 cycles
    initial begin
        #20000;
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
